// file: pkg/hspc_map.vh
// hspc_map.vh: register map, field positions, reset values and timing for the pulse counter
// assumes: included by bare name from rtl files; 32-bit AHB-Lite data, byte addresses
`ifndef HSPC_MAP_VH
`define HSPC_MAP_VH

// register byte offsets (haddr[9:0])
`define HSPC_CTRL_OFS 10'h000
`define HSPC_PV_OFS 10'h004
`define HSPC_NEWPV_OFS 10'h008
`define HSPC_NEWRMAX_OFS 10'h00C
`define HSPC_CMD_OFS 10'h010
`define HSPC_STAT_OFS 10'h014
`define HSPC_FREQ_OFS 10'h018
`define HSPC_INSIDE_OFS 10'h01C
`define HSPC_RMAX_OFS 10'h020
// table window: haddr[9] set, word index haddr[8:2]
`define HSPC_TBL_BIT 9

// control fields
`define HSPC_CTRL_MODE_LO 0
`define HSPC_CTRL_RING 2
`define HSPC_CTRL_RANGE 3
`define HSPC_CTRL_R32 4
`define HSPC_CTRL_EN 5
`define HSPC_CTRL_HIFREQ 6
`define HSPC_CTRL_TCNT_LO 8
`define HSPC_CTRL_RST 32'h0000_0000

// input modes
`define HSPC_MODE_QUAD 2'h0
`define HSPC_MODE_UP 2'h1
`define HSPC_MODE_UPDN 2'h2
`define HSPC_MODE_PDIR 2'h3

// command bits
`define HSPC_CMD_SET 0
`define HSPC_CMD_CLR 1

// status bits
`define HSPC_ST_CY 0
`define HSPC_ST_ER 1
`define HSPC_ST_MATCH 2
`define HSPC_ST_ENTER 3
`define HSPC_ST_LEAVE 4

// tables
`define HSPC_MAX_TARGETS 48
`define HSPC_RANGE_BASE 7'h40
`define HSPC_RANGES_SMALL 8
`define HSPC_RANGES_LARGE 32

// ring maximum loaded at power-on
`define HSPC_RMAX_RST 32'hFFFF_FFFF

// frequency sampling
`define HSPC_CLK_MHZ 100
`define HSPC_SAMPLE_US 10000
`define HSPC_SAMPLE_CYC (`HSPC_SAMPLE_US * `HSPC_CLK_MHZ)

`endif

// file: rtl/hspc_mem.v
// hspc_mem.v: target and range table, one write port, one registered read port
// assumes: single clock; write and read may target different words in one cycle
`timescale 1ns/1ps
`default_nettype none

module hspc_mem #(
	parameter AW = 7,
	parameter DW = 32
) (
	// clock
	input wire hclk,
	// write side
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [DW-1:0] wdata,
	// read side
	input wire [AW-1:0] raddr,
	output reg [DW-1:0] rdata_ff
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_ff <= mem[raddr];
	end

endmodule // hspc_mem

`default_nettype wire

// file: rtl/hspc_top.v
// hspc_top.v: one high-speed pulse counter with target/range compare, AHB-Lite register slave
// assumes: one 100 MHz clock hclk, async active-low hresetn; enc_a/enc_b are raw pins
// Operation
// - quadrature inputs decoded with x4 edges, 50 kHz line driver, 35 kHz 24 V
// - up, up/down and pulse-plus-direction modes, each up to 100 kHz
// - up to 48 target values; match flagged when count equals one
// - range compare alternative with 8 or 32 lower/upper ranges selectable
// - range compare raises events on entering and on leaving a range
// - linear mode spans full range; ring mode wraps between zero and ring maximum
// - ring maximum loaded at power-on, updated by set-counter-value command
// - high-frequency mode: count set or reset mid-sample sets carry flag
// - ring mode set value above ring maximum sets error flag
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hspc_map.vh"

module hspc_top #(
	parameter SAMPLE_CYC = `HSPC_SAMPLE_CYC,
	parameter [31:0] RMAX_INIT = `HSPC_RMAX_RST
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout_ff,
	output reg hresp_ff,
	output reg [31:0] hrdata_ff,
	// encoder pins
	input wire enc_a,
	input wire enc_b,
	// status outputs
	output reg carry_unreliable_flag_ff,
	output reg instruction_error_flag_ff
);

	////////////////////////////////////////////////////////////////////////
	// input conditioning: three stages, accept once stages two and three agree
	reg [2:0] a_sync_ff, b_sync_ff;
	reg a_ff, b_ff, a_prev_ff, b_prev_ff;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_sync_ff <= 3'h0;
			b_sync_ff <= 3'h0;
			a_ff <= 1'b0;
			b_ff <= 1'b0;
			a_prev_ff <= 1'b0;
			b_prev_ff <= 1'b0;
		end else begin
			a_sync_ff <= {a_sync_ff[1:0], enc_a};
			b_sync_ff <= {b_sync_ff[1:0], enc_b};
			if (a_sync_ff[1] == a_sync_ff[2]) a_ff <= a_sync_ff[2];
			if (b_sync_ff[1] == b_sync_ff[2]) b_ff <= b_sync_ff[2];
			a_prev_ff <= a_ff;
			b_prev_ff <= b_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	reg [31:0] ctrl_ff, pv_ff, newpv_ff, newrmax_ff, rmax_ff, freq_ff;
	reg [31:0] inside_ff;
	reg match_ff, enter_ff, leave_ff;

	wire [1:0] mode = ctrl_ff[`HSPC_CTRL_MODE_LO+1:`HSPC_CTRL_MODE_LO];
	wire ring = ctrl_ff[`HSPC_CTRL_RING];
	wire range_mode = ctrl_ff[`HSPC_CTRL_RANGE];
	wire [5:0] tcnt = ctrl_ff[`HSPC_CTRL_TCNT_LO+5:`HSPC_CTRL_TCNT_LO];

	////////////////////////////////////////////////////////////////////////
	// pulse decode
	wire a_rise = a_ff & ~a_prev_ff;
	wire b_rise = b_ff & ~b_prev_ff;
	wire a_chg = a_ff ^ a_prev_ff;
	wire b_chg = b_ff ^ b_prev_ff;
	reg inc, dec;

	always @* begin
		inc = 1'b0;
		dec = 1'b0;
		case (mode)
			`HSPC_MODE_QUAD: begin
				// every edge of either phase counts; both at once is a lost step
				if (a_chg ^ b_chg) begin
					inc = a_ff ^ b_prev_ff;
					dec = ~(a_ff ^ b_prev_ff);
				end
			end
			`HSPC_MODE_UP: inc = a_rise;
			`HSPC_MODE_UPDN: begin
				inc = a_rise & ~b_rise;
				dec = b_rise & ~a_rise;
			end
			`HSPC_MODE_PDIR: begin
				inc = a_rise & ~b_ff;
				dec = a_rise & b_ff;
			end
			default: begin
				inc = 1'b0;
				dec = 1'b0;
			end
		endcase
		if (!ctrl_ff[`HSPC_CTRL_EN]) begin
			inc = 1'b0;
			dec = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ahb-lite: one-cycle data phase, read data registered at the address edge
	wire addr_take = hsel & htrans[1] & hready;
	reg wr_pend_ff;
	reg [9:0] wr_addr_ff;

	wire wr = wr_pend_ff;
	wire tbl_wr = wr & wr_addr_ff[`HSPC_TBL_BIT];
	wire reg_wr = wr & ~wr_addr_ff[`HSPC_TBL_BIT];
	wire set_cmd = reg_wr & (wr_addr_ff == `HSPC_CMD_OFS) & hwdata[`HSPC_CMD_SET];
	wire clr_cmd = reg_wr & (wr_addr_ff == `HSPC_CMD_OFS) & hwdata[`HSPC_CMD_CLR];
	wire stat_wr = reg_wr & (wr_addr_ff == `HSPC_STAT_OFS);
	wire set_bad = ring & (newpv_ff > newrmax_ff);

	reg [31:0] rd_mux;
	always @* begin
		case (haddr[9:0])
			`HSPC_CTRL_OFS: rd_mux = ctrl_ff;
			`HSPC_PV_OFS: rd_mux = pv_ff;
			`HSPC_NEWPV_OFS: rd_mux = newpv_ff;
			`HSPC_NEWRMAX_OFS: rd_mux = newrmax_ff;
			`HSPC_STAT_OFS: rd_mux = {27'h0, leave_ff, enter_ff, match_ff,
				instruction_error_flag_ff, carry_unreliable_flag_ff};
			`HSPC_FREQ_OFS: rd_mux = freq_ff;
			`HSPC_INSIDE_OFS: rd_mux = inside_ff;
			`HSPC_RMAX_OFS: rd_mux = rmax_ff;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
			hrdata_ff <= 32'h0000_0000;
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 10'h000;
		end else begin
			wr_pend_ff <= addr_take & hwrite;
			if (addr_take) begin
				wr_addr_ff <= {haddr[9:2], 2'h0};
				hrdata_ff <= hwrite ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// present value, ring maximum and flags
	wire [31:0] pv_up = (ring && pv_ff >= rmax_ff) ? 32'h0000_0000 : pv_ff + 32'h0000_0001;
	wire [31:0] pv_dn = (ring && pv_ff == 32'h0000_0000) ? rmax_ff : pv_ff - 32'h0000_0001;
	reg sampling_ff;
	wire cy_set = ctrl_ff[`HSPC_CTRL_HIFREQ] & sampling_ff & (set_cmd | clr_cmd);
	wire ev_match, ev_enter, ev_leave;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= `HSPC_CTRL_RST;
			pv_ff <= 32'h0000_0000;
			newpv_ff <= 32'h0000_0000;
			newrmax_ff <= RMAX_INIT;
			rmax_ff <= RMAX_INIT;
			carry_unreliable_flag_ff <= 1'b0;
			instruction_error_flag_ff <= 1'b0;
			match_ff <= 1'b0;
			enter_ff <= 1'b0;
			leave_ff <= 1'b0;
		end else begin
			if (reg_wr && wr_addr_ff == `HSPC_CTRL_OFS) ctrl_ff <= hwdata;
			if (reg_wr && wr_addr_ff == `HSPC_NEWPV_OFS) newpv_ff <= hwdata;
			if (reg_wr && wr_addr_ff == `HSPC_NEWRMAX_OFS) newrmax_ff <= hwdata;
			// set command over reset over counting
			if (set_cmd) begin
				rmax_ff <= newrmax_ff;
				if (!set_bad) pv_ff <= newpv_ff;
			end else if (clr_cmd) begin
				pv_ff <= 32'h0000_0000;
			end else if (inc) begin
				pv_ff <= pv_up;
			end else if (dec) begin
				pv_ff <= pv_dn;
			end
			// sticky flags: a new event beats a write-one clear
			carry_unreliable_flag_ff <= cy_set |
				(carry_unreliable_flag_ff & ~(stat_wr & hwdata[`HSPC_ST_CY]));
			instruction_error_flag_ff <= (set_cmd & set_bad) |
				(instruction_error_flag_ff & ~(stat_wr & hwdata[`HSPC_ST_ER]));
			match_ff <= ev_match | (match_ff & ~(stat_wr & hwdata[`HSPC_ST_MATCH]));
			enter_ff <= ev_enter | (enter_ff & ~(stat_wr & hwdata[`HSPC_ST_ENTER]));
			leave_ff <= ev_leave | (leave_ff & ~(stat_wr & hwdata[`HSPC_ST_LEAVE]));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frequency sampling window
	reg [31:0] win_ff, acc_ff;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			win_ff <= 32'h0000_0000;
			acc_ff <= 32'h0000_0000;
			freq_ff <= 32'h0000_0000;
			sampling_ff <= 1'b0;
		end else begin
			sampling_ff <= 1'b1;
			if (win_ff >= SAMPLE_CYC - 1) begin
				win_ff <= 32'h0000_0000;
				freq_ff <= acc_ff + {31'h0, inc | dec};
				acc_ff <= 32'h0000_0000;
			end else begin
				win_ff <= win_ff + 32'h0000_0001;
				acc_ff <= acc_ff + {31'h0, inc | dec};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// table scan: one word a cycle; ranges are lower/upper word pairs
	reg [6:0] scan_ff, scan_d_ff;
	reg scan_v_ff;
	reg [31:0] lower_ff;
	wire [31:0] tbl_rd;
	wire [6:0] range_words = ctrl_ff[`HSPC_CTRL_R32] ? 7'h40 : 7'h10;
	wire [6:0] scan_last = range_mode ? range_words - 7'h01 :
		(tcnt > `HSPC_MAX_TARGETS ? 7'h2F : {1'b0, tcnt} - 7'h01);
	wire scan_on = range_mode | (tcnt != 6'h00);
	wire [6:0] scan_addr = range_mode ? (`HSPC_RANGE_BASE | scan_ff) : scan_ff;

	hspc_mem #(.AW(7), .DW(32)) u_tbl (
		.hclk(hclk),
		.we(tbl_wr),
		.waddr(wr_addr_ff[8:2]),
		.wdata(hwdata),
		.raddr(scan_addr),
		.rdata_ff(tbl_rd)
	);

	// signed compare in linear mode, unsigned in ring mode
	wire ge_lo = ring ? (pv_ff >= lower_ff) : ($signed(pv_ff) >= $signed(lower_ff));
	wire le_hi = ring ? (pv_ff <= tbl_rd) : ($signed(pv_ff) <= $signed(tbl_rd));
	wire now_in = ge_lo & le_hi;
	wire [4:0] rix = scan_d_ff[5:1];
	wire upper_v = scan_v_ff & range_mode & scan_d_ff[0];
	assign ev_match = scan_v_ff & ~range_mode & (tbl_rd == pv_ff);
	assign ev_enter = upper_v & now_in & ~inside_ff[rix];
	assign ev_leave = upper_v & ~now_in & inside_ff[rix];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scan_ff <= 7'h00;
			scan_d_ff <= 7'h00;
			scan_v_ff <= 1'b0;
			lower_ff <= 32'h0000_0000;
			inside_ff <= 32'h0000_0000;
		end else begin
			scan_ff <= (scan_ff >= scan_last) ? 7'h00 : scan_ff + 7'h01;
			scan_d_ff <= scan_ff;
			scan_v_ff <= scan_on;
			if (scan_v_ff && range_mode && !scan_d_ff[0]) lower_ff <= tbl_rd;
			if (!range_mode) inside_ff <= 32'h0000_0000;
			else if (upper_v) inside_ff[rix] <= now_in;
		end
	end

endmodule // hspc_top

`default_nettype wire

// file: test/hspc_top_monitor.sv
// hspc_top_monitor.sv: bus and flag checks on the counter's ports
// assumes: bound into hspc_top; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
`include "hspc_map.vh"
module hspc_top_monitor (
	// bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout_ff,
	input wire logic hresp_ff,
	input wire logic [31:0] hrdata_ff,
	// flags
	input wire logic carry_unreliable_flag_ff,
	input wire logic instruction_error_flag_ff
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [1:0] live_ff;
	logic stat_ff, cmd_ff;
	logic [2:0] age_ff;
	wire take = hsel && htrans[1] && hready;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			live_ff <= 2'h0;
			stat_ff <= 1'b0;
			cmd_ff <= 1'b0;
			age_ff <= 3'h7;
		end else begin
			live_ff <= {live_ff[0], 1'b1};
			stat_ff <= take && hwrite && haddr[9:0] == `HSPC_STAT_OFS;
			cmd_ff <= take && hwrite && haddr[9:0] == `HSPC_CMD_OFS;
			// saturates so old commands never look recent
			age_ff <= cmd_ff ? 3'h0 : (age_ff == 3'h7 ? 3'h7 : age_ff + 3'h1);
		end
	end
	sequence s_take;
		hsel && htrans[1] && hready;
	endsequence
	a_ready_high: assert property (hreadyout_ff) else $error("wait state seen");
	a_resp_okay: assert property (!hresp_ff) else $error("error response seen");
	a_rd_unmapped: assert property (s_take ##0 (!hwrite && (haddr[9] || haddr[9:0] > `HSPC_RMAX_OFS))
		|=> hrdata_ff == 32'h0) else $error("unmapped read not zero");
	a_wr_zero: assert property (s_take ##0 hwrite |=> hrdata_ff == 32'h0) else $error("write left read data");
	a_rd_hold: assert property (live_ff[1] && !take |=> $stable(hrdata_ff)) else $error("read data moved");
	a_carry_cause: assert property ($rose(carry_unreliable_flag_ff) |-> age_ff <= 3'h2)
		else $error("carry without command");
	a_err_cause: assert property ($rose(instruction_error_flag_ff) |-> age_ff <= 3'h2)
		else $error("error flag without command");
	a_carry_clear: assert property (live_ff[1] && $fell(carry_unreliable_flag_ff) |-> $past(stat_ff) && $past(hwdata[0]))
		else $error("carry dropped alone");
	a_err_clear: assert property (live_ff[1] && $fell(instruction_error_flag_ff) |-> $past(stat_ff) && $past(hwdata[1]))
		else $error("error flag dropped alone");
endmodule // hspc_top_monitor
bind hspc_top hspc_top_monitor mon_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
	.hrdata_ff(hrdata_ff), .carry_unreliable_flag_ff(carry_unreliable_flag_ff),
	.instruction_error_flag_ff(instruction_error_flag_ff));
`default_nettype wire

// file: test/hspc_enc_model.sv
// hspc_enc_model.sv: encoder and pulse source on the counter pins
// assumes: tasks called from tb; edges kept within rated rates
`timescale 1ns/1ps
`default_nettype none
module hspc_enc_model (
	// clock
	input wire logic hclk,
	// pins
	output logic enc_a,
	output logic enc_b
);
	// a leads b when counting up
	localparam logic [7:0] GRAY = 8'h78;
	logic [1:0] ph = 2'h0;
	initial begin
		enc_a = 1'b0;
		enc_b = 1'b0;
	end
	task quad(input logic up, input int n);
		repeat (n) begin
			ph = up ? ph + 2'h1 : ph - 2'h1;
			@(posedge hclk);
			{enc_a, enc_b} <= GRAY[2*ph +: 2];
			repeat (500) @(posedge hclk);
		end
	endtask
	// b is left alone on a pulses so it can serve as direction
	task pulse(input logic on_b, input int n);
		repeat (n) begin
			@(posedge hclk);
			if (on_b) enc_b <= 1'b1; else enc_a <= 1'b1;
			repeat (500) @(posedge hclk);
			if (on_b) enc_b <= 1'b0; else enc_a <= 1'b0;
			repeat (500) @(posedge hclk);
		end
	endtask
	task dir(input logic d);
		@(posedge hclk);
		enc_b <= d;
		repeat (500) @(posedge hclk);
	endtask
endmodule // hspc_enc_model
`default_nettype wire

// file: test/tb.sv
// tb.sv: directed scenarios for the pulse counter
// assumes: single slave, hready fed back from hreadyout
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic hclk, hresetn, hsel, hwrite, rdy, cy, er, ea, eb;
	logic [31:0] haddr, hwdata, rdata, v;
	logic [1:0] htrans;
	int failures, checks_done, cyc;
	hspc_top #(.SAMPLE_CYC(50)) hspc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout_ff(rdy),
		.hresp_ff(), .hrdata_ff(rdata), .enc_a(ea), .enc_b(eb), .carry_unreliable_flag_ff(cy),
		.instruction_error_flag_ff(er));
	hspc_enc_model enc (.hclk(hclk), .enc_a(ea), .enc_b(eb));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (rdy !== 1'b1);
		v = rdata;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rc(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(v, e);
	endtask
	task t_regs;
		rc(32'h000, 32'h0);
		rc(32'h004, 32'h0);
		rc(32'h020, 32'hFFFF_FFFF);
		rc(32'h024, 32'h0);
		rc(32'h200, 32'h0);
		$display("done regs");
	endtask
	task t_quad;
		wr(32'h000, 32'h20);
		enc.quad(1'b1, 8);
		rc(32'h004, 32'h8);
		enc.quad(1'b0, 12);
		rc(32'h004, 32'hFFFF_FFFC);
		$display("done quad");
	endtask
	task t_modes;
		wr(32'h010, 32'h2);
		wr(32'h000, 32'h21);
		enc.pulse(1'b0, 3);
		enc.pulse(1'b1, 1);
		rc(32'h004, 32'h3);
		wr(32'h000, 32'h22);
		enc.pulse(1'b1, 2);
		enc.pulse(1'b0, 1);
		rc(32'h004, 32'h2);
		wr(32'h000, 32'h23);
		enc.dir(1'b1);
		enc.pulse(1'b0, 1);
		enc.dir(1'b0);
		enc.pulse(1'b0, 2);
		rc(32'h004, 32'h3);
		$display("done modes");
	endtask
	task t_ring;
		wr(32'h000, 32'h25);
		wr(32'h00C, 32'h5);
		wr(32'h008, 32'h5);
		wr(32'h010, 32'h1);
		rc(32'h020, 32'h5);
		rc(32'h004, 32'h5);
		enc.pulse(1'b0, 1);
		rc(32'h004, 32'h0);
		wr(32'h000, 32'h26);
		enc.pulse(1'b1, 1);
		rc(32'h004, 32'h5);
		wr(32'h008, 32'h6);
		wr(32'h010, 32'h1);
		rc(32'h004, 32'h5);
		chk({31'h0, er}, 32'h1);
		wr(32'h014, 32'h2);
		rc(32'h014, 32'h0);
		$display("done ring");
	endtask
	task t_carry;
		wr(32'h000, 32'h61);
		wr(32'h010, 32'h2);
		rc(32'h004, 32'h0);
		chk({31'h0, cy}, 32'h1);
		wr(32'h014, 32'h1);
		rc(32'h014, 32'h0);
		$display("done carry");
	endtask
	task t_target;
		wr(32'h000, 32'h121);
		wr(32'h200, 32'h3);
		wr(32'h014, 32'h1F);
		enc.pulse(1'b0, 2);
		rc(32'h014, 32'h0);
		enc.pulse(1'b0, 1);
		rc(32'h014, 32'h4);
		$display("done target");
	endtask
	task t_range;
		wr(32'h000, 32'h0);
		wr(32'h010, 32'h2);
		for (int i = 0; i < 64; i++) wr(32'h300 + 4 * i, i < 2 ? 32'h2 + i : 32'h7FFF_0000);
		wr(32'h000, 32'h39);
		repeat (100) @(posedge hclk);
		wr(32'h014, 32'h1F);
		enc.pulse(1'b0, 2);
		rc(32'h014, 32'h8);
		wr(32'h014, 32'h1F);
		enc.pulse(1'b0, 2);
		rc(32'h014, 32'h10);
		// range 8 covers the count but lies outside the small table
		wr(32'h000, 32'h29);
		wr(32'h340, 32'h4);
		wr(32'h344, 32'h8);
		repeat (100) @(posedge hclk);
		wr(32'h014, 32'h1F);
		rc(32'h014, 32'h0);
		wr(32'h000, 32'h39);
		repeat (100) @(posedge hclk);
		rc(32'h014, 32'h8);
		rc(32'h01C, 32'h100);
		$display("done range");
	endtask
	task close_out;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures++;
			close_out;
		end
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_quad;
		t_modes;
		t_ring;
		t_carry;
		t_target;
		t_range;
		close_out;
	end
endmodule // tb
`default_nettype wire
